// ===== src/pmc_pkg.sv
// package for the power mode control register block
// assumes an 8-bit special-function register port driven by the core
package pmc_pkg;
  localparam logic [7:0] ADDR_WAKE_RELOAD = 8'h86;
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h87;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h8c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h8d;
  localparam logic [7:0] WAKE_RELOAD_RST = 8'h00;
  localparam logic [7:0] PWR_CTRL_COLD = 8'h10;
  localparam logic [7:0] PWR_CTRL_WRITE_MASK = 8'hdf;
  localparam int BIT_BAUD_DOUBLE = 7;
  localparam int BIT_FE_SEL = 6;
  localparam int BIT_POWERON = 4;
  localparam int BIT_USER_ONE = 3;
  localparam int BIT_USER_ZERO = 2;
  localparam int BIT_POWERDOWN = 1;
  localparam int BIT_IDLE = 0;
  localparam int IRQ_BITS = 3;
  localparam int IRQ_ENTER_IDLE = 0;
  localparam int IRQ_ENTER_PD = 1;
  localparam int IRQ_WAKE = 2;

  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_IDLE = 2'b01,
    PMC_POWERDOWN = 2'b11
  } pmc_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmc_bus_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic pc_hold;
  } pmc_clk_s;
endpackage : pmc_pkg

// ===== src/pmc_regs.sv
// power mode control registers: wake-up reload byte and power control
// assumes one clock, a power-on reset and a separate warm reset pulse
//
// What this block does
// - wake reload byte is read/write, eight bits, zero after reset
// - baud_double bit drives the serial baud doubling output
// - frame_err_access_sel steers serial control bit 7 to mode or error
// - power-on reset sets poweron flag, control reads 0x10
// - warm reset keeps poweron flag, clears other control bits
// - two user flags at bits 3 and 2, no side effect
// - after service routine, execution resumes after the entry point
// - idle plus power-down together gives power-down only, no idle after
// - idle request stops cpu clock only, pc held, peripherals run
// - wake from idle clears idle request, then interrupt service runs
`timescale 1ns/100ps
`default_nettype none
module pmc_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic warm_reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic wake_event,
  output logic [7:0] wakeup_reload_byte,
  output logic baud_double,
  output logic frame_err_access_sel,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic pc_hold,
  output logic wake_isr_req,
  output logic irq
);
  pmc_pkg::pmc_bus_s bus;
  pmc_pkg::pmc_clk_s clk_ctl;
  pmc_pkg::pmc_mode_e mode_reg, mode_next;
  logic [7:0] reload_reg;
  logic [7:0] pctl_reg, pctl_next;
  logic [pmc_pkg::IRQ_BITS-1:0] stat_reg, stat_next, mask_reg;
  logic [pmc_pkg::IRQ_BITS-1:0] stat_set;
  logic [7:0] rdata_next;
  logic wr_reload, wr_pctl, wr_stat, wr_mask;
  logic warm_q1, warm_q2, warm_q3, warm_hit;
  logic wake_now, enter_pd, enter_idle;

  // bus carrier and address decode
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_reload = bus.wr && bus.addr == pmc_pkg::ADDR_WAKE_RELOAD;
  assign wr_pctl = bus.wr && bus.addr == pmc_pkg::ADDR_PWR_CTRL;
  assign wr_stat = bus.wr && bus.addr == pmc_pkg::ADDR_IRQ_STATUS;
  assign wr_mask = bus.wr && bus.addr == pmc_pkg::ADDR_IRQ_MASK;

  // warm reset pin: three stages, acts when stages two and three agree low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      warm_q1 <= 1'b1;
      warm_q2 <= 1'b1;
      warm_q3 <= 1'b1;
    end else begin
      warm_q1 <= warm_reset_n;
      warm_q2 <= warm_q1;
      warm_q3 <= warm_q2;
    end
  end
  assign warm_hit = !warm_q2 && !warm_q3;

  // low-power entry and wake decisions
  // power-down wins
  assign enter_pd = wr_pctl && bus.wdata[pmc_pkg::BIT_POWERDOWN];
  assign enter_idle = wr_pctl && bus.wdata[pmc_pkg::BIT_IDLE] && !enter_pd;
  assign wake_now = wake_event && mode_reg != pmc_pkg::PMC_RUN;

  // next power control value
  always_comb begin
    pctl_next = pctl_reg;
    if (wr_pctl) begin
      pctl_next = bus.wdata & pmc_pkg::PWR_CTRL_WRITE_MASK;
      if (enter_pd) begin
        pctl_next[pmc_pkg::BIT_IDLE] = 1'b0;
      end
    end
    if (wake_now) begin
      pctl_next[pmc_pkg::BIT_POWERDOWN] = 1'b0;
      pctl_next[pmc_pkg::BIT_IDLE] = 1'b0;
    end
  end

  // mode sequencing
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      pmc_pkg::PMC_RUN: begin
        if (enter_pd) begin
          mode_next = pmc_pkg::PMC_POWERDOWN;
        end else if (enter_idle) begin
          mode_next = pmc_pkg::PMC_IDLE;
        end
      end
      // wake returns to run, pc resumes where it was held
      pmc_pkg::PMC_IDLE, pmc_pkg::PMC_POWERDOWN: begin
        if (wake_event) begin
          mode_next = pmc_pkg::PMC_RUN;
        end
      end
      default: mode_next = pmc_pkg::PMC_RUN;
    endcase
  end

  // clock gating drawn from the next mode
  // power-down stops both clocks
  assign clk_ctl.cpu_clk_en = mode_next == pmc_pkg::PMC_RUN;
  assign clk_ctl.periph_clk_en = mode_next != pmc_pkg::PMC_POWERDOWN;
  assign clk_ctl.pc_hold = mode_next != pmc_pkg::PMC_RUN;

  // interrupt status: set wins over clear
  assign stat_set[pmc_pkg::IRQ_ENTER_IDLE] = enter_idle;
  assign stat_set[pmc_pkg::IRQ_ENTER_PD] = enter_pd;
  assign stat_set[pmc_pkg::IRQ_WAKE] = wake_now;
  assign stat_next = (stat_reg & ~({pmc_pkg::IRQ_BITS{wr_stat}}
    & bus.wdata[pmc_pkg::IRQ_BITS-1:0])) | stat_set;

  // read data mux, unmapped reads zero
  always_comb begin
    rdata_next = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        pmc_pkg::ADDR_WAKE_RELOAD: rdata_next = reload_reg;
        pmc_pkg::ADDR_PWR_CTRL: rdata_next = pctl_reg;
        pmc_pkg::ADDR_IRQ_STATUS: rdata_next = 8'(stat_reg);
        pmc_pkg::ADDR_IRQ_MASK: rdata_next = 8'(mask_reg);
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // power control register with poweron flag
  // cold start value
  // warm reset keeps only the poweron flag
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pctl_reg <= pmc_pkg::PWR_CTRL_COLD;
    end else if (warm_hit) begin
      pctl_reg <= pctl_reg & pmc_pkg::PWR_CTRL_COLD;
    end else begin
      pctl_reg <= pctl_next;
    end
  end

  // remaining state, cleared by either reset
  // reload byte storage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reload_reg <= pmc_pkg::WAKE_RELOAD_RST;
      mode_reg <= pmc_pkg::PMC_RUN;
      stat_reg <= '0;
      mask_reg <= '0;
    end else if (warm_hit) begin
      reload_reg <= pmc_pkg::WAKE_RELOAD_RST;
      mode_reg <= pmc_pkg::PMC_RUN;
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      reload_reg <= wr_reload ? bus.wdata : reload_reg;
      mode_reg <= mode_next;
      stat_reg <= stat_next;
      mask_reg <= wr_mask ? bus.wdata[pmc_pkg::IRQ_BITS-1:0] : mask_reg;
    end
  end

  // registered outputs
  // baud doubling
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      wakeup_reload_byte <= pmc_pkg::WAKE_RELOAD_RST;
      baud_double <= 1'b0;
      frame_err_access_sel <= 1'b0;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      pc_hold <= 1'b0;
      wake_isr_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= rdata_next;
      wakeup_reload_byte <= warm_hit ? pmc_pkg::WAKE_RELOAD_RST : reload_reg;
      baud_double <= !warm_hit && pctl_next[pmc_pkg::BIT_BAUD_DOUBLE];
      frame_err_access_sel <= !warm_hit && pctl_next[pmc_pkg::BIT_FE_SEL];
      cpu_clk_en <= warm_hit || clk_ctl.cpu_clk_en;
      periph_clk_en <= warm_hit || clk_ctl.periph_clk_en;
      pc_hold <= !warm_hit && clk_ctl.pc_hold;
      // service routine of the waking source is requested
      wake_isr_req <= !warm_hit && wake_now;
      irq <= !warm_hit && |(stat_next & mask_reg);
    end
  end

  // both bits written gives power-down, idle bit cleared
  a_pd_over_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    enter_pd && mode_reg == pmc_pkg::PMC_RUN && !warm_hit
      |=> mode_reg == pmc_pkg::PMC_POWERDOWN
      && !pctl_reg[pmc_pkg::BIT_IDLE]) else $error("pd not taken alone");
  a_pd_clocks_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_reg == pmc_pkg::PMC_POWERDOWN |-> !cpu_clk_en && !periph_clk_en
      && pc_hold) else $error("clocks running in power-down");
  a_idle_clocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_reg == pmc_pkg::PMC_IDLE |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");
  a_wake_clr_pd: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wake_now && !warm_hit |=> !pctl_reg[pmc_pkg::BIT_POWERDOWN]
      && wake_isr_req && mode_reg == pmc_pkg::PMC_RUN)
    else $error("wake did not clear request");
  // wake from idle clears idle bit
  a_wake_clr_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wake_now && mode_reg == pmc_pkg::PMC_IDLE && !warm_hit
      |=> !pctl_reg[pmc_pkg::BIT_IDLE]) else $error("idle bit left set");
  a_bit5_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 wr_pctl |=> pctl_reg[5] == 1'b0) else $error("bit 5 not zero");
  a_warm_keep_pof: assert property (@(posedge clk_sys) disable iff (!reset_n)
    warm_hit |=> pctl_reg == ($past(pctl_reg) & pmc_pkg::PWR_CTRL_COLD))
    else $error("warm reset control value wrong");
  // reload write visible on read two cycles on
  a_reload_rw: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_reload && !warm_hit ##1 (bus.rd && bus.addr == pmc_pkg::ADDR_WAKE_RELOAD
      && !warm_hit && !wr_reload) |=> reg_rdata == $past(bus.wdata, 2))
    else $error("reload readback wrong");
  a_user_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_pctl && !warm_hit |=> pctl_reg[3:2] == $past(bus.wdata[3:2]))
    else $error("user flags not stored");
  a_baud_double: assert property (@(posedge clk_sys) disable iff (!reset_n)
    baud_double == pctl_reg[pmc_pkg::BIT_BAUD_DOUBLE]
      && frame_err_access_sel == pctl_reg[pmc_pkg::BIT_FE_SEL])
    else $error("serial control bits mismatch");
  // read data zero outside the answer cycle
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !bus.rd |=> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  // reload output follows the register one cycle later
  a_reload_mirror: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !warm_hit |=> wakeup_reload_byte == $past(reload_reg))
    else $error("reload output wrong");
  // wake in run mode is ignored
  a_run_no_wake: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_reg == pmc_pkg::PMC_RUN && wake_event |=> !wake_isr_req)
    else $error("wake taken in run mode");
  a_idle_entry: assert property (@(posedge clk_sys) disable iff (!reset_n)
    enter_idle && mode_reg == pmc_pkg::PMC_RUN && !warm_hit
      |=> mode_reg == pmc_pkg::PMC_IDLE && pc_hold)
    else $error("idle not entered");
  a_idle_stays: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_reg == pmc_pkg::PMC_IDLE && !wake_event && !warm_hit
      |=> mode_reg == pmc_pkg::PMC_IDLE) else $error("idle left early");
  a_wake_resume: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wake_now && !warm_hit |=> cpu_clk_en && periph_clk_en && !pc_hold)
    else $error("execution not resumed");
  a_pd_exit_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_reg == pmc_pkg::PMC_POWERDOWN && wake_event && !warm_hit
      |=> mode_reg == pmc_pkg::PMC_RUN && !pctl_reg[pmc_pkg::BIT_IDLE])
    else $error("idle after power-down");
  // wake status is sticky, set wins over clear
  a_wake_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wake_now && !warm_hit |=> stat_reg[pmc_pkg::IRQ_WAKE])
    else $error("wake status not set");
  a_cold_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(reset_n) |-> pctl_reg == pmc_pkg::PWR_CTRL_COLD
      && reload_reg == pmc_pkg::WAKE_RELOAD_RST) else $error("cold value");
  // poweron flag changes only by software write
  a_pof_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !wr_pctl |=> pctl_reg[pmc_pkg::BIT_POWERON]
      == $past(pctl_reg[pmc_pkg::BIT_POWERON])) else $error("pof changed");
  a_bit5_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    bus.rd && bus.addr == pmc_pkg::ADDR_PWR_CTRL |=> !reg_rdata[5])
    else $error("bit 5 read not zero");
  // steering select follows its written bit
  a_fe_sel_wr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_pctl && !warm_hit |=> frame_err_access_sel
      == $past(bus.wdata[pmc_pkg::BIT_FE_SEL])) else $error("fe sel wrong");
  // baud doubling follows its written bit
  a_baud_wr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_pctl && !warm_hit && !wake_now |=> baud_double
      == $past(bus.wdata[pmc_pkg::BIT_BAUD_DOUBLE])) else $error("baud wrong");
endmodule : pmc_regs
`default_nettype wire

// ===== testbench/tb.sv
// testbench for the power mode control register block
// assumes pmc_regs with a 20 MHz clock and a one-cycle read data port
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} pmc_row_s;
  logic clk_sys, reset_n, warm_reset_n, reg_wr, reg_rd, wake_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, reload_out;
  logic baud_double, frame_err_access_sel, cpu_clk_en, periph_clk_en;
  logic pc_hold, wake_isr_req, irq;
  int miscompares = 0;
  int checked = 0;
  pmc_row_s rows [6];

  pmc_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .warm_reset_n(warm_reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wake_event(wake_event),
    .wakeup_reload_byte(reload_out), .baud_double(baud_double),
    .frame_err_access_sel(frame_err_access_sel), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .pc_hold(pc_hold),
    .wake_isr_req(wake_isr_req), .irq(irq));

  // clock at 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data checked in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd

  // single-cycle wake pulse, isr request looked at in its one cycle
  task automatic wake;
    @(posedge clk_sys);
    wake_event <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    #1;
    check({7'h00, wake_isr_req}, 8'h01);
  endtask : wake

  // warm reset held long enough for the synchroniser
  task automatic warm;
    @(posedge clk_sys);
    warm_reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    warm_reset_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask : warm

  // verdict in one place
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // watchdog well beyond the expected run length
  initial begin
    #100000;
    miscompares++;
    test_done();
  end

  initial begin
    reset_n = 1'b0;
    warm_reset_n = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    wake_event = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    rows = '{'{8'h86, 8'h5a, 8'h5a}, '{8'h86, 8'hfe, 8'hfe},
      '{8'h87, 8'hec, 8'hcc}, '{8'h87, 8'h00, 8'h00},
      '{8'h90, 8'h55, 8'h00}, '{8'h8d, 8'h00, 8'h00}};
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(pmc_pkg::ADDR_WAKE_RELOAD, 8'h00);
    rd(pmc_pkg::ADDR_PWR_CTRL, 8'h10);
    $display("test reset done");
    // ordinary write and read back cases
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
    end
    wr(pmc_pkg::ADDR_WAKE_RELOAD, 8'ha5);
    @(posedge clk_sys);
    #1;
    check(reload_out, 8'ha5);
    wr(pmc_pkg::ADDR_PWR_CTRL, 8'h80);
    repeat (2) @(posedge clk_sys);
    check({6'h00, baud_double, frame_err_access_sel}, 8'h02);
    wr(pmc_pkg::ADDR_PWR_CTRL, 8'h40);
    repeat (2) @(posedge clk_sys);
    check({6'h00, baud_double, frame_err_access_sel}, 8'h01);
    $display("test table done");
    wr(pmc_pkg::ADDR_PWR_CTRL, 8'h01);
    repeat (2) @(posedge clk_sys);
    check({5'h00, cpu_clk_en, periph_clk_en, pc_hold}, 8'h03);
    wake();
    @(posedge clk_sys);
    check({5'h00, cpu_clk_en, periph_clk_en, pc_hold}, 8'h06);
    rd(pmc_pkg::ADDR_PWR_CTRL, 8'h00);
    $display("test idle done");
    wr(pmc_pkg::ADDR_PWR_CTRL, 8'h03);
    repeat (2) @(posedge clk_sys);
    check({5'h00, cpu_clk_en, periph_clk_en, pc_hold}, 8'h01);
    rd(pmc_pkg::ADDR_PWR_CTRL, 8'h02);
    wake();
    @(posedge clk_sys);
    check({5'h00, cpu_clk_en, periph_clk_en, pc_hold}, 8'h06);
    rd(pmc_pkg::ADDR_PWR_CTRL, 8'h00);
    $display("test power-down done");
    // sticky status, mask, level interrupt, write-one clear
    rd(pmc_pkg::ADDR_IRQ_STATUS, 8'h07);
    check({7'h00, irq}, 8'h00);
    wr(pmc_pkg::ADDR_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk_sys);
    check({7'h00, irq}, 8'h01);
    wr(pmc_pkg::ADDR_IRQ_STATUS, 8'h04);
    repeat (2) @(posedge clk_sys);
    check({7'h00, irq}, 8'h00);
    rd(pmc_pkg::ADDR_IRQ_STATUS, 8'h03);
    $display("test interrupt done");
    // warm reset keeps the power-on flag either way
    // software clears the flag after reading it
    wr(pmc_pkg::ADDR_PWR_CTRL, 8'hcc);
    warm();
    rd(pmc_pkg::ADDR_PWR_CTRL, 8'h00);
    rd(pmc_pkg::ADDR_WAKE_RELOAD, 8'h00);
    wr(pmc_pkg::ADDR_PWR_CTRL, 8'h1c);
    warm();
    rd(pmc_pkg::ADDR_PWR_CTRL, 8'h10);
    $display("test warm reset done");
    // write then read with no gap between strobes
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= pmc_pkg::ADDR_WAKE_RELOAD;
    reg_wdata <= 8'h3c;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, 8'h3c);
    $display("test back to back done");
    test_done();
  end
endmodule : tb
`default_nettype wire
